// file: hdl/sfr_pkg.sv
// sfr_pkg: register map, field layout, reset values and counts of the
// security fault response block; assumes a 32-bit AHB-Lite register bus.
package sfr_pkg;
  // register byte offsets
  localparam logic [7:0] RST_CAUSE_OFS  = 8'h00;
  localparam logic [7:0] EXC_STATUS_OFS = 8'h04;
  localparam logic [7:0] EXC_MASK_OFS   = 8'h08;
  localparam logic [7:0] NVM_LIGHT_OFS  = 8'h0C;
  localparam logic [7:0] HV_STATUS_OFS  = 8'h10;
  localparam logic [7:0] SENSOR_OFS     = 8'h14;
  localparam logic [7:0] TEST_LOCK_OFS  = 8'h18;
  localparam logic [7:0] MODE_OFS       = 8'h1C;
  // reset cause bit positions
  localparam int RC_VOLT = 0;
  localparam int RC_FREQ = 1;
  localparam int RC_TEMP = 2;
  localparam int RC_LIGHT = 3;
  localparam int RC_ROM = 4;
  localparam int RC_W = 5;
  // exception status bit positions
  localparam int EX_NVM_LIGHT = 0;
  localparam int EX_PC = 1;
  localparam int EX_SP = 2;
  localparam int EX_PSW = 3;
  localparam int EX_DES = 4;
  localparam int EX_MOD = 5;
  localparam int EX_STK_USR = 6;
  localparam int EX_STK_SYS = 7;
  localparam int EX_STK_PRV = 8;
  localparam int EX_W = 9;
  // values after reset
  localparam logic [EX_W-1:0] EXC_MASK_RST  = 9'h1FF;
  localparam logic [1:0]      NVM_LIGHT_RST = 2'h1;
  // stack limits, one per mode group
  localparam logic [15:0] STK_LIM_USR = 16'h0FFF;
  localparam logic [15:0] STK_LIM_SYS = 16'h1FFF;
  localparam logic [15:0] STK_LIM_PRV = 16'h2FFF;
  // length of the chip reset request
  localparam int  RST_PULSE_NS = 100;
  localparam int  CLK_MHZ = 100;
  localparam int  RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RST_PULSE_CNT = 4'(RST_PULSE_CYC);
  // selector of the privileged mode group
  typedef enum logic [1:0] {SFR_PRV_BOOT, SFR_PRV_TEST, SFR_PRV_CLESS} sfr_prv_t;
endpackage

// file: hdl/sfr_top.sv
// sfr_top: fault response unit, routes alarms to chip reset or cpu exception.
// assumes hresetn is power-on reset only; chip_reset_req resets the rest of
// the chip and, in this block, only trap, light select and mode state, so the reset cause survives it.
// Notes on behaviour
// [RQ1] supply, clock, temperature or light sensor alarm forces a chip reset
// [RQ2] memory light or single-fault alarm raises cpu exception, not reset
// [RQ3] every reset returns all state to defined reset values; chip reset here leaves exc_mask, test_lock and hv status as they were
// [RQ4] readable reset cause keeps the source of the latest reset
// [RQ5] readable exception reason shown whenever an exception is raised
// [RQ6] outside factory test mode all sensors are enabled automatically
// [RQ7] software writes cannot disable the sensors
// [RQ8] alarm to reset or exception mapping fixed in hardware
// [RQ9] three stack range checkers, one per mode group, raise exception at limit
// [RQ10] programming voltage checked each write sequence, result readable, no event
// [RQ11] memory offers two light detectors: choose one or disable both
// [RQ12] memory reads correct any single-bit error within each byte
// [RQ13] program rom parity error forces a chip reset
// [RQ14] fault detection covers pc, sp, status word, des and modular unit
// [RQ15] factory test mode can be locked off, sensors then stay in force
// [RQ16] privileged group is boot, test or contactless mode, chosen here
// [RQ17] reset alarm wins over exception alarm in the same cycle
`timescale 1ns/1ps
module sfr_top
  import sfr_pkg::*;
(
  input  wire logic        hclk,            // system clock
  input  wire logic        hresetn,         // power-on reset, active low
  input  wire logic        hsel,            // slave select
  input  wire logic [31:0] haddr,           // address
  input  wire logic [1:0]  htrans,          // transfer type
  input  wire logic        hwrite,          // write
  input  wire logic [2:0]  hsize,           // size
  input  wire logic [31:0] hwdata,          // write data
  input  wire logic        hready,          // bus ready
  output logic      [31:0] hrdata,          // read data
  output logic             hreadyout,       // slave ready
  output logic             hresp,           // response
  input  wire logic        sens_volt,       // supply alarm, async
  input  wire logic        sens_freq,       // clock alarm, async
  input  wire logic        sens_temp,       // temperature alarm, async
  input  wire logic        sens_light,      // light alarm, async
  input  wire logic [1:0]  nvm_light_alarm, // memory light detectors, async
  input  wire logic        hv_ok,           // programming voltage good, async
  input  wire logic        nvm_write_busy,  // write sequence active
  input  wire logic        flt_pc,          // fault on program counter
  input  wire logic        flt_sp,          // fault on stack pointer
  input  wire logic        flt_psw,         // fault on program_status_high_word
  input  wire logic        flt_des,         // fault in des unit
  input  wire logic        flt_mod,         // fault in modular unit
  input  wire logic        rom_parity_err,  // rom parity error
  input  wire logic [1:0]  cpu_mode,        // 0 user, 1 system
  input  wire logic        privileged_mode_flag, // privileged group active
  input  wire logic [15:0] sp_usr,          // user stack pointer
  input  wire logic [15:0] sp_sys,          // system stack pointer
  input  wire logic [15:0] sp_prv,          // privileged stack pointer
  input  wire logic        test_fuse_off,   // test mode fused off
  input  wire logic        test_request,    // test mode wanted
  input  wire logic        boot_done,       // boot phase over
  input  wire logic [31:0] nvm_rdata,       // raw memory read data
  input  wire logic [15:0] nvm_check,       // 4 check bits per byte
  output logic      [31:0] nvm_fixed,       // corrected read data
  output logic      [1:0]  nvm_light_en,    // light detector enables
  output logic             sensors_en,      // analogue sensor enable
  output logic      [1:0]  prv_mode,        // privileged group selector
  output logic             chip_reset_req,  // chip reset request
  output logic             cpu_exception,   // exception pulse
  output logic             irq              // unmasked status pending
);

  // single-bit correction of one byte with four check bits
  function automatic logic [7:0] fix_byte(input logic [7:0] d, input logic [3:0] c);
    logic [3:0] s;
    logic [7:0] o;
    s[0] = c[0] ^ d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    s[1] = c[1] ^ d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    s[2] = c[2] ^ d[1] ^ d[2] ^ d[3] ^ d[7];
    s[3] = c[3] ^ d[4] ^ d[5] ^ d[6] ^ d[7];
    o = d;
    case (s)
      4'h3: o[0] = ~d[0];
      4'h5: o[1] = ~d[1];
      4'h6: o[2] = ~d[2];
      4'h7: o[3] = ~d[3];
      4'h9: o[4] = ~d[4];
      4'hA: o[5] = ~d[5];
      4'hB: o[6] = ~d[6];
      4'hC: o[7] = ~d[7];
      default: o = d;
    endcase
    return o;
  endfunction

  // register decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // three-stage synchronisers on all asynchronous inputs
  localparam int NS = 7;
  logic [NS-1:0] async_in;
  logic [NS-1:0] s1, s2, s3;
  logic [NS-1:0] sync_lv;
  assign async_in = {hv_ok, nvm_light_alarm, sens_light, sens_temp, sens_freq, sens_volt};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      // level changes once stage two and three agree
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1[gi]      <= 1'b0;
          s2[gi]      <= 1'b0;
          s3[gi]      <= 1'b0;
          sync_lv[gi] <= 1'b0;
        end else begin
          s1[gi] <= async_in[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            sync_lv[gi] <= s3[gi];
          end
        end
      end
    end
  endgenerate

  // test availability and sensor enable
  logic test_lock, test_on;
  // [RQ15] lock ends test
  assign test_on = test_request & ~test_fuse_off & ~test_lock;

  // [RQ6] sensors enabled automatically
  logic sens_act;
  assign sens_act = ~test_on;

  // reset-class alarms, hard-wired
  logic [RC_W-1:0] rst_src;
  // [RQ1] sensor alarms reset
  // [RQ8] fixed routing
  assign rst_src[RC_VOLT]  = sens_act & sync_lv[0];
  assign rst_src[RC_FREQ]  = sens_act & sync_lv[1];
  assign rst_src[RC_TEMP]  = sens_act & sync_lv[2];
  assign rst_src[RC_LIGHT] = sens_act & sync_lv[3];
  // [RQ13] rom parity reset
  assign rst_src[RC_ROM]   = rom_parity_err;

  // stack range checks, one per mode group
  logic [2:0] stk_hit, stk_hit_q;
  logic [1:0] light_q;
  // [RQ9] threefold stack check
  assign stk_hit[0] = ~privileged_mode_flag & (cpu_mode == 2'd0) & (sp_usr >= STK_LIM_USR);
  assign stk_hit[1] = ~privileged_mode_flag & (cpu_mode == 2'd1) & (sp_sys >= STK_LIM_SYS);
  assign stk_hit[2] = privileged_mode_flag & (sp_prv >= STK_LIM_PRV);

  // exception-class alarms, hard-wired
  logic [EX_W-1:0] exc_src;
  logic [1:0]      nvm_light_sel;
  // [RQ2] memory light and faults trap
  // [RQ11] selected light function
  assign exc_src[EX_NVM_LIGHT] = |(sync_lv[5:4] & ~light_q & nvm_light_en);
  // [RQ14] covered units
  assign exc_src[EX_PC]  = flt_pc;
  assign exc_src[EX_SP]  = flt_sp;
  assign exc_src[EX_PSW] = flt_psw;
  assign exc_src[EX_DES] = flt_des;
  assign exc_src[EX_MOD] = flt_mod;
  assign exc_src[EX_STK_USR] = stk_hit[0] & ~stk_hit_q[0];
  assign exc_src[EX_STK_SYS] = stk_hit[1] & ~stk_hit_q[1];
  assign exc_src[EX_STK_PRV] = stk_hit[2] & ~stk_hit_q[2];

  logic rst_now, exc_now;
  assign rst_now = |rst_src;
  // [RQ17] reset beats exception
  assign exc_now = (|exc_src) & ~rst_now & ~chip_reset_req;

  // stack and light alarm edge memory; a held alarm traps only once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stk_hit_q <= 3'h0;
      light_q   <= 2'h0;
    end else begin
      stk_hit_q <= stk_hit;
      light_q   <= sync_lv[5:4];
    end
  end
  // bus address phase capture
  logic       wr_pend, rd_go, wr_go;
  logic [7:0] wr_addr;
  assign rd_go = hsel & hready & htrans[1] & ~hwrite;
  assign wr_go = hsel & hready & htrans[1] & hwrite;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= wr_go;
      wr_addr <= haddr[7:0];
    end
  end

  logic wr_mask, wr_light, wr_lock;
  assign wr_mask  = wr_pend & hit(wr_addr, EXC_MASK_OFS);
  assign wr_light = wr_pend & hit(wr_addr, NVM_LIGHT_OFS);
  assign wr_lock  = wr_pend & hit(wr_addr, TEST_LOCK_OFS);

  // reset request pulse and cause record
  logic [3:0]      rst_cnt;
  logic [RC_W-1:0] rst_cause;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_cnt        <= 4'h0;
      chip_reset_req <= 1'b0;
      rst_cause      <= '0;
    end else if (rst_now && !chip_reset_req) begin
      // [RQ4] cause of latest reset
      rst_cnt        <= RST_PULSE_CNT;
      chip_reset_req <= 1'b1;
      rst_cause      <= rst_src;
    end else if (rst_cnt > 4'h1) begin
      rst_cnt <= rst_cnt - 4'h1;
    end else begin
      rst_cnt        <= 4'h0;
      chip_reset_req <= 1'b0;
    end
  end

  // exception status, mask, pulse and irq
  logic [EX_W-1:0] exc_stat, exc_mask;
  logic            rd_stat;
  assign rd_stat = rd_go & hit(haddr[7:0], EXC_STATUS_OFS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_stat      <= '0;
      cpu_exception <= 1'b0;
    end else if (chip_reset_req) begin
      // [RQ3] chip reset clears trap state
      exc_stat      <= '0;
      cpu_exception <= 1'b0;
    end else begin
      // [RQ5] exception reason kept
      // set wins over read clear
      exc_stat      <= (rd_stat ? '0 : exc_stat) | (exc_now ? exc_src : '0);
      cpu_exception <= exc_now;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_mask <= EXC_MASK_RST;
    end else if (wr_mask) begin
      exc_mask <= hwdata[EX_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(exc_stat & exc_mask);
    end
  end

  // memory light selection: 1 first, 2 second, else none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm_light_sel <= NVM_LIGHT_RST;
    end else if (chip_reset_req) begin
      nvm_light_sel <= NVM_LIGHT_RST;
    end else if (wr_light) begin
      nvm_light_sel <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nvm_light_en <= 2'h0;
    end else begin
      // [RQ11] one or none enabled
      case (nvm_light_sel)
        2'h1:    nvm_light_en <= 2'h1;
        2'h2:    nvm_light_en <= 2'h2;
        default: nvm_light_en <= 2'h0;
      endcase
    end
  end

  // test lock is sticky until power-on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_lock <= 1'b0;
    end else if (wr_lock && hwdata[0]) begin
      // [RQ15] software lock of test
      test_lock <= 1'b1;
    end
  end

  // sensor enable, writes to its register are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sensors_en <= 1'b1;
    end else begin
      // [RQ7] no software off switch
      sensors_en <= sens_act;
    end
  end

  // privileged group selection
  logic boot_over;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_over <= 1'b0;
      prv_mode  <= SFR_PRV_BOOT;
    end else if (chip_reset_req) begin
      boot_over <= 1'b0;
      prv_mode  <= SFR_PRV_BOOT;
    end else if (!boot_over) begin
      // [RQ16] boot then test or contactless
      if (boot_done) begin
        boot_over <= 1'b1;
        prv_mode  <= test_on ? SFR_PRV_TEST : SFR_PRV_CLESS;
      end
    end else if (!test_on) begin
      prv_mode <= SFR_PRV_CLESS;
    end
  end

  // programming voltage check per write sequence
  logic busy_q, hv_bad, hv_done, hv_pass;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q  <= 1'b0;
      hv_bad  <= 1'b0;
      hv_done <= 1'b0;
      hv_pass <= 1'b0;
    end else begin
      busy_q <= nvm_write_busy;
      // [RQ10] check during sequence
      if (nvm_write_busy && !busy_q) begin
        hv_bad <= ~sync_lv[6];
      end else if (nvm_write_busy && !sync_lv[6]) begin
        hv_bad <= 1'b1;
      end
      // result stored at end, no event raised
      if (!nvm_write_busy && busy_q) begin
        hv_done <= 1'b1;
        hv_pass <= ~hv_bad;
      end
    end
  end

  // corrected memory read data
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ecc
      // [RQ12] per byte single-bit fix
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          nvm_fixed[gi*8 +: 8] <= 8'h00;
        end else begin
          nvm_fixed[gi*8 +: 8] <= fix_byte(nvm_rdata[gi*8 +: 8], nvm_check[gi*4 +: 4]);
        end
      end
    end
  endgenerate

  // read mux, evaluated in address phase
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      RST_CAUSE_OFS:  next_rdata[RC_W-1:0] = rst_cause;
      EXC_STATUS_OFS: next_rdata[EX_W-1:0] = exc_stat;
      EXC_MASK_OFS:   next_rdata[EX_W-1:0] = exc_mask;
      NVM_LIGHT_OFS:  next_rdata[1:0] = nvm_light_sel;
      HV_STATUS_OFS:  next_rdata[1:0] = {hv_done, hv_pass};
      SENSOR_OFS:     next_rdata[0] = sensors_en;
      TEST_LOCK_OFS:  next_rdata[1:0] = {test_on, test_lock};
      MODE_OFS:       next_rdata[1:0] = prv_mode;
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // zero wait state slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_go) begin
        hrdata <= next_rdata;
      end
    end
  end

endmodule // sfr_top

// file: tb/sfr_checker.sv
// sfr_checker: timing checks on the ports of the fault response block.
// assumes one clock domain and the async power-on reset of the block.
`timescale 1ns/1ps
module sfr_checker
  import sfr_pkg::*;
(
  input  wire logic        hclk,                 // clock
  input  wire logic        hresetn,              // reset
  input  wire logic        sens_volt,            // alarm
  input  wire logic        sens_freq,            // alarm
  input  wire logic        sens_temp,            // alarm
  input  wire logic        sens_light,           // alarm
  input  wire logic        flt_pc,               // fault
  input  wire logic        flt_sp,               // fault
  input  wire logic        flt_psw,              // fault
  input  wire logic        flt_des,              // fault
  input  wire logic        flt_mod,              // fault
  input  wire logic        rom_parity_err,       // parity
  input  wire logic [1:0]  cpu_mode,             // mode
  input  wire logic        privileged_mode_flag, // group
  input  wire logic [15:0] sp_usr,               // stack
  input  wire logic        test_fuse_off,        // fuse
  input  wire logic        test_request,         // test
  input  wire logic        sensors_en,           // enable
  input  wire logic        chip_reset_req,       // reset out
  input  wire logic        cpu_exception         // exception
);
  wire logic any_sens = sens_volt | sens_freq | sens_temp | sens_light;
  wire logic any_rst  = any_sens | rom_parity_err | chip_reset_req;
  logic [2:0] quiet;
  wire logic calm = (quiet == 3'h7) && !any_rst;
  // calm cycles since a reset alarm; sync stages must drain first
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      quiet <= 3'h0;
    else if (any_rst)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rom_rst;
    rom_parity_err |=> chip_reset_req;
  endproperty
  a_rom_rst: assert property (p_rom_rst)
    else $error("parity error gave no reset request");
  property p_sens_rst;
    !any_sens ##1 any_sens[*4] |-> ##[0:4] chip_reset_req;
  endproperty
  a_sens_rst: assert property (p_sens_rst)
    else $error("sensor alarm gave no reset request");
  property p_rst_len;
    $rose(chip_reset_req) |-> chip_reset_req[*8] ##1 chip_reset_req ##1 chip_reset_req;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset request shorter than ten cycles");
  property p_rst_wins;
    $rose(chip_reset_req) |-> !cpu_exception;
  endproperty
  a_rst_wins: assert property (p_rst_wins)
    else $error("exception raised with a reset");
  property p_flt_exc;
    calm && (flt_pc | flt_sp | flt_psw | flt_des | flt_mod) |=> cpu_exception;
  endproperty
  a_flt_exc: assert property (p_flt_exc)
    else $error("fault gave no exception");
  property p_stk_exc;
    calm && cpu_mode == 2'h0 && !privileged_mode_flag && $stable(cpu_mode) && $stable(privileged_mode_flag)
      && sp_usr >= STK_LIM_USR && $past(sp_usr) < STK_LIM_USR |=> cpu_exception;
  endproperty
  a_stk_exc: assert property (p_stk_exc)
    else $error("user stack limit gave no exception");
  property p_sens_on;
    !test_request && !$past(test_request) |-> sensors_en;
  endproperty
  a_sens_on: assert property (p_sens_on)
    else $error("sensors off outside test mode");
  property p_fuse;
    test_fuse_off && $past(test_fuse_off) |-> sensors_en;
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("sensors off on a fused part");
endmodule // sfr_checker
bind sfr_top sfr_checker sfr_checker_i (.hclk, .hresetn, .sens_volt, .sens_freq, .sens_temp, .sens_light,
  .flt_pc, .flt_sp, .flt_psw, .flt_des, .flt_mod, .rom_parity_err, .cpu_mode, .privileged_mode_flag,
  .sp_usr, .test_fuse_off, .test_request, .sensors_en, .chip_reset_req, .cpu_exception);

// file: tb/sfr_cpu_model.sv
// sfr_cpu_model: cpu side partner, runs memory write sequences, counts exceptions.
// assumes start is a one-cycle pulse from the bench.
`timescale 1ns/1ps
module sfr_cpu_model (
  input  wire logic       hclk,    // clock
  input  wire logic       hresetn, // reset
  input  wire logic       start,   // begin a write
  input  wire logic       bad,     // sag the voltage
  input  wire logic [3:0] len,     // busy cycles
  input  wire logic       exc,     // exception pulse
  output logic            busy,    // write active
  output logic            hv_ok,   // voltage good
  output logic      [7:0] exc_cnt  // exceptions seen
);
  logic [3:0] left;
  // write sequencer; a bad run sags the voltage for its whole length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left  <= 4'h0;
      busy  <= 1'b0;
      hv_ok <= 1'b1;
    end else if (start) begin
      left  <= len;
      busy  <= 1'b1;
      hv_ok <= !bad;
    end else if (left != 4'h0) begin
      left  <= left - 4'h1;
      busy  <= left != 4'h1;
      hv_ok <= (left == 4'h1) | hv_ok;
    end
  end
  // exception entries taken by the core
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      exc_cnt <= 8'h00;
    else if (exc)
      exc_cnt <= exc_cnt + 8'h01;
endmodule // sfr_cpu_model

// file: tb/tb_top.sv
// tb_top: self-checking bench of the fault response block.
// assumes a single 100 MHz clock and power-on reset only.
`timescale 1ns/1ps
module tb_top;
  import sfr_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0;
  logic        rom = 1'b0, prv = 1'b0, fuse = 1'b0, treq = 1'b0, boot = 1'b0, start = 1'b0, bad = 1'b0;
  logic        hready, hreadyout, hresp, hv_ok, busy, sensors_en, chip_reset_req, cpu_exception, irq;
  logic [31:0] haddr = '0, hwdata = '0, nvm_rdata = '0, hrdata, nvm_fixed, d;
  logic [1:0]  htrans = '0, cpu_mode = '0, nvm_light_alarm = '0, nvm_light_en, prv_mode;
  logic [1:0]  lsel [3] = '{2'h2, 2'h0, 2'h1};
  logic [15:0] lim [3] = '{STK_LIM_USR, STK_LIM_SYS, STK_LIM_PRV};
  logic [15:0] sp [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] nvm_check = '0;
  logic [3:0]  sens = '0, len = 4'h4;
  logic [4:0]  flt = '0;
  logic [7:0]  exc_cnt;
  logic [31:0] rd_q [$];
  int          err_total = 0, cmp_count = 0, cyc = 0;
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  sfr_top sfr_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .sens_volt(sens[0]), .sens_freq(sens[1]), .sens_temp(sens[2]),
    .sens_light(sens[3]), .nvm_light_alarm, .hv_ok, .nvm_write_busy(busy), .flt_pc(flt[0]),
    .flt_sp(flt[1]), .flt_psw(flt[2]), .flt_des(flt[3]), .flt_mod(flt[4]), .rom_parity_err(rom),
    .cpu_mode, .privileged_mode_flag(prv), .sp_usr(sp[0]), .sp_sys(sp[1]), .sp_prv(sp[2]),
    .test_fuse_off(fuse), .test_request(treq), .boot_done(boot), .nvm_rdata, .nvm_check, .nvm_fixed,
    .nvm_light_en, .sensors_en, .prv_mode, .chip_reset_req, .cpu_exception, .irq);
  sfr_cpu_model sfr_cpu_model_i (.hclk, .hresetn, .start, .bad, .len, .exc(cpu_exception), .busy,
    .hv_ok, .exc_cnt);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer; on a read d is the expected word
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w)
      rd_q.push_back(d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel    <= 1'b0;
    htrans  <= 2'h0;
    hwdata  <= d;
    rd_pend <= !w;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_pend <= 1'b0;
  endtask
  task automatic wait_rst(input logic v);
    for (int k = 0; k < 40 && chip_reset_req !== v; k++)
      @(posedge hclk) #1;
    chk("chip_reset_req", {31'h0, chip_reset_req}, {31'h0, v});
  endtask
  function automatic logic [15:0] hcode(input logic [31:0] v);
    for (int b = 0; b < 4; b++)
      hcode[4*b +: 4] = {^(v[8*b +: 8] & 8'hf0), ^(v[8*b +: 8] & 8'h8e), ^(v[8*b +: 8] & 8'h6d),
                         ^(v[8*b +: 8] & 8'h5b)};
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // read data against the oldest note, at the data phase edge
  always @(posedge hclk)
    if (rd_pend && hready === 1'b1)
      chk("hrdata", hrdata, rd_q.pop_front());
  // hang guard, the run needs a few hundred cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'hf7ac));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    boot    <= 1'b1;
    for (int m = 0; m < 3; m++)
      sp[m] <= lim[m] - 16'($urandom_range(32'h0000_00ff)) - 16'h0001;
    bus(1'b0, EXC_MASK_OFS, 32'h0000_01ff);
    bus(1'b0, NVM_LIGHT_OFS, 32'h0000_0001);
    bus(1'b0, RST_CAUSE_OFS, '0);
    bus(1'b0, 8'h40, '0);
    chk("nvm_light_en", {30'h0, nvm_light_en}, 32'h0000_0001);
    chk("prv_mode", {30'h0, prv_mode}, {30'h0, SFR_PRV_CLESS});
    chk("hresp", {31'h0, hresp}, '0);
    for (int i = 0; i < 5; i++) begin
      @(posedge hclk) flt <= 5'h01 << i;
      @(posedge hclk) flt <= 5'h00;
      #1 chk("cpu_exception", {31'h0, cpu_exception}, 32'h0000_0001);
      @(posedge hclk) #1 chk("irq", {31'h0, irq}, 32'h0000_0001);
      bus(1'b0, EXC_STATUS_OFS, 32'h0000_0002 << i);
      bus(1'b0, EXC_STATUS_OFS, '0);
    end
    bus(1'b1, EXC_MASK_OFS, '0);
    @(posedge hclk) flt <= 5'h08;
    @(posedge hclk) flt <= 5'h00;
    repeat (2) @(posedge hclk);
    #1 chk("irq", {31'h0, irq}, '0);
    bus(1'b0, EXC_STATUS_OFS, 32'h0000_0010);
    bus(1'b1, EXC_MASK_OFS, 32'h0000_01ff);
    for (int m = 0; m < 3; m++) begin
      @(posedge hclk) cpu_mode <= 2'(m);
      prv <= (m == 2);
      @(posedge hclk) sp[m] <= lim[m];
      repeat (2) @(posedge hclk);
      bus(1'b0, EXC_STATUS_OFS, 32'h0000_0040 << m);
      sp[m] <= lim[m] - 16'h0010;
    end
    prv      <= 1'b0;
    cpu_mode <= 2'h0;
    // light function select, only the chosen one alarms
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, NVM_LIGHT_OFS, {30'h0, lsel[k]});
      repeat (2) @(posedge hclk);
      #1 chk("nvm_light_en", {30'h0, nvm_light_en}, {30'h0, lsel[k]});
      @(posedge hclk) nvm_light_alarm <= 2'h1;
      repeat (6) @(posedge hclk);
      nvm_light_alarm <= 2'h0;
      bus(1'b0, EXC_STATUS_OFS, {31'h0, lsel[k] == 2'h1});
    end
    bus(1'b1, SENSOR_OFS, '0);
    bus(1'b0, SENSOR_OFS, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk) start <= 1'b1;
      bad <= (k == 1);
      len <= 4'($urandom_range(32'h0000_000c, 32'h0000_0005));
      @(posedge hclk) start <= 1'b0;
      repeat (16) @(posedge hclk);
      bus(1'b0, HV_STATUS_OFS, {30'h0, 1'b1, k == 0});
    end
    for (int k = 0; k < 8; k++) begin
      d = $urandom;
      @(posedge hclk) nvm_rdata <= d ^ (32'h0000_0001 << $urandom_range(32'h0000_001f));
      nvm_check <= hcode(d);
      @(posedge hclk) #1 chk("nvm_fixed", nvm_fixed, d);
    end
    // fuse and lock keep sensors on
    @(posedge hclk) treq <= 1'b1;
    fuse <= 1'b1;
    repeat (3) @(posedge hclk);
    #1 chk("sensors_en", {31'h0, sensors_en}, 32'h0000_0001);
    @(posedge hclk) fuse <= 1'b0;
    repeat (3) @(posedge hclk);
    #1 chk("sensors_en", {31'h0, sensors_en}, '0);
    bus(1'b1, TEST_LOCK_OFS, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    #1 chk("sensors_en", {31'h0, sensors_en}, 32'h0000_0001);
    treq <= 1'b0;
    // reset alarms, parity beside a fault
    for (int i = 0; i < 5; i++) begin
      @(posedge hclk) {rom, sens} <= 5'h01 << i;
      flt <= {4'h0, i == 4};
      wait_rst(1'b1);
      {rom, sens} <= '0;
      flt <= '0;
      wait_rst(1'b0);
      bus(1'b0, RST_CAUSE_OFS, 32'h0000_0001 << i);
    end
    bus(1'b0, EXC_STATUS_OFS, '0);
    chk("exc_cnt", {24'h0, exc_cnt}, 32'h0000_000a);
    tally_and_finish;
  end
endmodule // tb_top
